/* logic/ckr_pkg.sv */
// Contract
// - Register one bits 3:1 gate processor clocks.
// - Register one bit 5 zero selects down spread.
// - Register two bits 6:0 gate peripheral clocks.
// - Register three bit 7 picks 24/48 MHz.
// - Register three bits 5,4 gate fixed outputs.
// - Register three bits 1,0 gate reference outputs.
// - Register four gates memory clocks thirteen to eight.
// - Register five gates memory clocks seven to zero.
// - Register six is fixed read-only identifier.
// - Write: address, command, count, then bytes.
// - Read: address then bytes from zero until stop.
// - Defaults load only at power-up reset.
package ckr_pkg;

  // Seven-bit serial slave address.
  localparam logic [6:0] CKR_SLAVE_ADDR = 7'h69;
  // Bits in one serial byte.
  localparam logic [3:0] CKR_BYTE_BITS = 4'h8;
  // Register indices as they appear in the byte stream.
  localparam logic [2:0] CKR_IDX_FREQ = 3'h0;
  localparam logic [2:0] CKR_IDX_PROC = 3'h1;
  localparam logic [2:0] CKR_IDX_PERI = 3'h2;
  localparam logic [2:0] CKR_IDX_FIXD = 3'h3;
  localparam logic [2:0] CKR_IDX_MEMH = 3'h4;
  localparam logic [2:0] CKR_IDX_MEML = 3'h5;
  localparam logic [2:0] CKR_IDX_CHIP = 3'h6;
  localparam logic [2:0] CKR_IDX_LAST = 3'h7;
  // Read value past the last register.
  localparam logic [7:0] CKR_EMPTY_BYTE = 8'hFF;
  // Power-up values of the stored registers, index 5 first.
  localparam logic [5:0][7:0] CKR_RESET =
    {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00};
  // Bits that software may change, index 5 first.
  localparam logic [5:0][7:0] CKR_WMASK =
    {8'hFF, 8'hF5, 8'hB3, 8'h7F, 8'h2E, 8'hFF};
  // Reserved bits of registers one, two and three.
  localparam logic [7:0] CKR_RES_PROC = 8'h51;
  localparam logic [7:0] CKR_RES_PERI = 8'h80;
  localparam logic [7:0] CKR_RES_FIXD = 8'h0C;
  // Field positions.
  localparam int CKR_B_STRAP2 = 7;
  localparam int CKR_B_SPREAD = 5;
  localparam int CKR_B_SEL24 = 7;
  localparam int CKR_B_STRAP0 = 6;
  localparam int CKR_B_FIX48 = 5;
  localparam int CKR_B_SELFIX = 4;
  localparam int CKR_B_REF2 = 1;
  localparam int CKR_B_REFX2 = 0;
  localparam int CKR_B_STRAP1 = 3;
  localparam int CKR_B_MEM9 = 2;
  localparam int CKR_B_STRAP3 = 1;
  localparam int CKR_B_MEM8 = 0;
  // Strap capture waits this many cycles for the synchroniser.
  localparam logic [1:0] CKR_CAP_WAIT = 2'h2;

  // Serial protocol states, Gray coded along the usual path.
  typedef enum logic [2:0] {
    CKR_ST_IDLE = 3'h0,
    CKR_ST_ADDR = 3'h1,
    CKR_ST_CMD = 3'h3,
    CKR_ST_CNT = 3'h2,
    CKR_ST_WR = 3'h6,
    CKR_ST_RD = 3'h7,
    CKR_ST_SKIP = 3'h5
  } ckr_state_e;

  // Run enables for every gated clock output, 1 means running, plus the 24 MHz and down-spread selects.
  typedef struct packed {
    logic [2:0] processor_clock_out;
    logic [6:0] peripheral_bus_clock_out;
    logic [13:0] memory_clock_out;
    logic second_reference_out;
    logic double_strength_reference_out;
    logic fixed_48_out;
    logic selectable_fixed_out;
    logic selectable_is_24mhz;
    logic down_spread;
  } ckr_run_s;

endpackage

/* logic/ckr_regs.sv */
`timescale 1ns/1ns
module ckr_regs
  import ckr_pkg::*;
#(
  // Identifier byte; the value is arbitrary.
  parameter logic [7:0] CHIP_ID = 8'hA5
)
(
  // Clock and power-up reset.
  input wire logic clock,
  input wire logic rst,
  // Two-wire serial pins; data is open drain.
  input wire logic serial_clock_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  // Frequency-select strap pins.
  input wire logic [3:0] freq_strap,
  // Clock output control.
  output ckr_run_s clock_run,
  output logic [7:0] freq_ctrl_byte
);

  // Synchroniser stages and delayed copies for edge detection.
  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [3:0] strap_s1_reg, strap_s2_reg;
  // Protocol state.
  ckr_state_e state_reg, state_next;
  logic [3:0] bit_reg, bit_next;
  logic ack_reg, ack_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [2:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  // Stored registers zero to five.
  logic [5:0][7:0] ctrl_reg, ctrl_next;
  // Latched strap levels, inverted, and capture timer.
  logic [3:0] strap_reg, strap_next;
  logic [1:0] cap_reg, cap_next;
  logic cap_done_reg, cap_done_next;
  // Bus events decoded from the synchronised lines.
  logic scl_rise, scl_fall, bus_start, bus_stop;
  // Write strobe for the byte in shift_reg.
  logic wr_en;

  // Value that a read returns for a given register index.
  function automatic logic [7:0] read_byte(input logic [2:0] idx);
    logic [7:0] v;
    v = CKR_EMPTY_BYTE;
    if (idx < CKR_IDX_CHIP)
    begin
      v = ctrl_reg[idx];
    end
    if (idx == CKR_IDX_CHIP)
    begin
      v = CHIP_ID;
    end
    if (idx == CKR_IDX_PROC)
    begin
      v[CKR_B_STRAP2] = strap_reg[2];
    end
    if (idx == CKR_IDX_FIXD)
    begin
      v[CKR_B_STRAP0] = strap_reg[0];
    end
    if (idx == CKR_IDX_MEMH)
    begin
      v[CKR_B_STRAP1] = strap_reg[1];
      v[CKR_B_STRAP3] = strap_reg[3];
    end
    return v;
  endfunction

  // Edges are seen on the second stage against its delayed copy.
  assign scl_rise = scl_s2_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s2_reg & scl_d_reg;
  assign bus_start = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
  assign bus_stop = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

  // Serial protocol and register update.
  always_comb
  begin
    state_next = state_reg;
    bit_next = bit_reg;
    ack_next = ack_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    ctrl_next = ctrl_reg;
    wr_en = 1'b0;
    if (bus_start)
    begin
      // A start, repeated or not, always restarts at byte zero.
      state_next = CKR_ST_ADDR;
      bit_next = 4'h0;
      ack_next = 1'b0;
      oe_next = 1'b0;
      ptr_next = CKR_IDX_FREQ;
    end
    else if (bus_stop)
    begin
      // A stop ends any transfer and frees the data line.
      state_next = CKR_ST_IDLE;
      ack_next = 1'b0;
      oe_next = 1'b0;
    end
    else if (state_reg != CKR_ST_IDLE && state_reg != CKR_ST_SKIP)
    begin
      if (scl_rise)
      begin
        if (ack_reg)
        begin
          if (state_reg == CKR_ST_RD && sda_s2_reg)
          begin
            state_next = CKR_ST_SKIP;
          end
        end
        else if (bit_reg < CKR_BYTE_BITS)
        begin
          shift_next = {shift_reg[6:0], sda_s2_reg};
          bit_next = bit_reg + 4'h1;
        end
      end
      if (scl_fall)
      begin
        if (ack_reg)
        begin
          // Leave the ack slot; in a read, put out the next byte.
          ack_next = 1'b0;
          bit_next = 4'h0;
          oe_next = 1'b0;
          if (state_reg == CKR_ST_RD)
          begin
            tx_next = read_byte(ptr_reg);
            oe_next = ~tx_next[7];
            if (ptr_reg != CKR_IDX_LAST)
            begin
              ptr_next = ptr_reg + 3'h1;
            end
          end
        end
        else if (bit_reg == CKR_BYTE_BITS)
        begin
          // Byte complete: enter the ack slot.
          ack_next = 1'b1;
          unique case (state_reg)
            CKR_ST_ADDR:
            begin
              if (shift_reg[7:1] == CKR_SLAVE_ADDR)
              begin
                oe_next = 1'b1;
                state_next = shift_reg[0] ? CKR_ST_RD : CKR_ST_CMD;
              end
              else
              begin
                state_next = CKR_ST_SKIP;
              end
            end
            CKR_ST_CMD:
            begin
              oe_next = 1'b1;
              state_next = CKR_ST_CNT;
            end
            CKR_ST_CNT:
            begin
              oe_next = 1'b1;
              state_next = CKR_ST_WR;
            end
            CKR_ST_WR:
            begin
              oe_next = 1'b1;
              wr_en = 1'b1;
              if (ptr_reg != CKR_IDX_LAST)
              begin
                ptr_next = ptr_reg + 3'h1;
              end
            end
            default:
            begin
              // Read: release the line for the host's ack.
              oe_next = 1'b0;
            end
          endcase
        end
        else if (state_reg == CKR_ST_RD)
        begin
          // Next bit of the byte, most significant first.
          tx_next = {tx_reg[6:0], 1'b0};
          oe_next = ~tx_reg[6];
        end
      end
    end
    if (wr_en && ptr_reg < CKR_IDX_CHIP)
    begin
      ctrl_next[ptr_reg] = (ctrl_reg[ptr_reg] & ~CKR_WMASK[ptr_reg]) |
                           (shift_reg & CKR_WMASK[ptr_reg]);
    end
  end

  // Strap capture once the synchroniser holds settled levels.
  always_comb
  begin
    strap_next = strap_reg;
    cap_next = cap_reg;
    cap_done_next = cap_done_reg;
    if (!cap_done_reg)
    begin
      if (cap_reg == CKR_CAP_WAIT)
      begin
        strap_next = ~strap_s2_reg;
        cap_done_next = 1'b1;
      end
      else
      begin
        cap_next = cap_reg + 2'h1;
      end
    end
  end

  // Registers; only the power-up reset reloads the defaults, so a
  // start, stop or aborted transfer never disturbs the settings.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_s1_reg <= 4'h0;
      strap_s2_reg <= 4'h0;
      state_reg <= CKR_ST_IDLE;
      bit_reg <= 4'h0;
      ack_reg <= 1'b0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= CKR_IDX_FREQ;
      oe_reg <= 1'b0;
      ctrl_reg <= CKR_RESET;
      strap_reg <= 4'h0;
      cap_reg <= 2'h0;
      cap_done_reg <= 1'b0;
    end
    else
    begin
      scl_s1_reg <= serial_clock_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= serial_data_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      strap_s1_reg <= freq_strap;
      strap_s2_reg <= strap_s1_reg;
      state_reg <= state_next;
      bit_reg <= bit_next;
      ack_reg <= ack_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      ctrl_reg <= ctrl_next;
      strap_reg <= strap_next;
      cap_reg <= cap_next;
      cap_done_reg <= cap_done_next;
    end
  end

  // Open drain: the line is only ever pulled low.
  assign serial_data_out = 1'b0;
  assign serial_data_oe = oe_reg;
  assign freq_ctrl_byte = ctrl_reg[CKR_IDX_FREQ];
  assign clock_run.processor_clock_out = ctrl_reg[CKR_IDX_PROC][3:1];
  assign clock_run.down_spread = ~ctrl_reg[CKR_IDX_PROC][CKR_B_SPREAD];
  assign clock_run.peripheral_bus_clock_out = ctrl_reg[CKR_IDX_PERI][6:0];
  assign clock_run.selectable_is_24mhz = ctrl_reg[CKR_IDX_FIXD][CKR_B_SEL24];
  assign clock_run.fixed_48_out = ctrl_reg[CKR_IDX_FIXD][CKR_B_FIX48];
  assign clock_run.selectable_fixed_out = ctrl_reg[CKR_IDX_FIXD][CKR_B_SELFIX];
  assign clock_run.second_reference_out = ctrl_reg[CKR_IDX_FIXD][CKR_B_REF2];
  assign clock_run.double_strength_reference_out =
    ctrl_reg[CKR_IDX_FIXD][CKR_B_REFX2];
  assign clock_run.memory_clock_out = {ctrl_reg[CKR_IDX_MEMH][7:4],
    ctrl_reg[CKR_IDX_MEMH][CKR_B_MEM9],
    ctrl_reg[CKR_IDX_MEMH][CKR_B_MEM8], ctrl_reg[CKR_IDX_MEML]};

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_wr(logic [2:0] idx);
    wr_en && ptr_reg == idx;
  endsequence

  property p_proc_gate;
    s_wr(CKR_IDX_PROC) |=> clock_run.processor_clock_out ==
      $past(shift_reg[3:1]);
  endproperty
  a_proc_gate: assert property (p_proc_gate)
    else $error("Processor gates not written.");

  property p_spread;
    s_wr(CKR_IDX_PROC) |=> clock_run.down_spread == !$past(shift_reg[5]);
  endproperty
  a_spread: assert property (p_spread)
    else $error("Spread type not written.");

  property p_peri;
    s_wr(CKR_IDX_PERI) ##1 1'b1 |-> clock_run.peripheral_bus_clock_out ==
      $past(shift_reg[6:0]) && ctrl_reg[CKR_IDX_PERI][7];
  endproperty
  a_peri: assert property (p_peri)
    else $error("Peripheral gates wrong.");

  property p_fixd;
    s_wr(CKR_IDX_FIXD) |=> clock_run.selectable_is_24mhz ==
      $past(shift_reg[7]) && clock_run.fixed_48_out == $past(shift_reg[5])
      && clock_run.second_reference_out == $past(shift_reg[1]);
  endproperty
  a_fixd: assert property (p_fixd)
    else $error("Fixed output control wrong.");

  property p_memh;
    s_wr(CKR_IDX_MEMH) |=> clock_run.memory_clock_out[13:10] ==
      $past(shift_reg[7:4]) && clock_run.memory_clock_out[8] ==
      $past(shift_reg[0]) && clock_run.memory_clock_out[9] ==
      $past(shift_reg[2]);
  endproperty
  a_memh: assert property (p_memh)
    else $error("High memory gates wrong.");

  property p_meml;
    s_wr(CKR_IDX_MEML) |=> clock_run.memory_clock_out[7:0] ==
      $past(shift_reg);
  endproperty
  a_meml: assert property (p_meml)
    else $error("Low memory gates wrong.");

  property p_chip;
    scl_fall && ack_reg && state_reg == CKR_ST_RD &&
      ptr_reg == CKR_IDX_CHIP |=> tx_reg == CHIP_ID;
  endproperty
  a_chip: assert property (p_chip)
    else $error("Identifier byte wrong.");

  property p_res;
    (ctrl_reg[CKR_IDX_PROC] & CKR_RES_PROC) == CKR_RES_PROC &&
      (ctrl_reg[CKR_IDX_FIXD] & CKR_RES_FIXD) == CKR_RES_FIXD &&
      (ctrl_reg[CKR_IDX_PERI] & CKR_RES_PERI) == CKR_RES_PERI;
  endproperty
  a_res: assert property (p_res)
    else $error("Reserved bit lost its one.");

  property p_ack;
    scl_fall && !ack_reg && bit_reg == CKR_BYTE_BITS &&
      (state_reg == CKR_ST_CMD || state_reg == CKR_ST_CNT) |=>
      serial_data_oe && ack_reg;
  endproperty
  a_ack: assert property (p_ack)
    else $error("Dummy byte not acknowledged.");

endmodule

/* tb/ckr_host_model.sv */
`timescale 1ns/1ns
module ckr_host_model
(
  // System clock that paces every serial phase.
  input wire logic clock,
  // Wired data line level, and what the host drives.
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Half a serial bit in system clocks; the device needs at least 2.
  localparam int HALF = 10;

  // Lines idle released, serial clock high.
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask

  // One bit each way; data moves only well after the clock falls,
  // because the device sees both lines through synchronisers.
  task automatic xbit(input logic b, output logic r);
    sda_pull <= ~b;
    wt(HALF);
    scl <= 1'b1;
    wt(HALF / 2);
    @(negedge clock) r = sda;
    wt(HALF / 2);
    scl <= 1'b0;
    wt(3);
  endtask

  // Start: data falls while the clock is high.
  task automatic start();
    sda_pull <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(HALF);
    sda_pull <= 1'b1;
    wt(HALF);
    scl <= 1'b0;
    wt(3);
  endtask

  // Stop: data rises while the clock is high.
  task automatic stop();
    sda_pull <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(HALF);
    sda_pull <= 1'b0;
    wt(HALF);
  endtask

  // Eight bits, most significant first, then the acknowledge bit.
  task automatic xbyte(input logic [7:0] d, input logic ab,
    output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(d[i], r);
      q[i] = r;
    end
    xbit(ab, ack);
  endtask

  // Sends one byte and counts an acknowledge from the device.
  task automatic put(input logic [7:0] d, inout int acks);
    logic [7:0] q;
    logic a;
    xbyte(d, 1'b1, q, a);
    acks += int'(a === 1'b0);
  endtask

  task automatic write_regs(input logic [7:0] addr,
    input logic [7:0][7:0] d, input int n, output int acks);
    acks = 0;
    start();
    put(addr, acks);
    put(8'h00, acks);
    put(8'hC3, acks);
    for (int i = 0; i < n; i++)
      put(d[i], acks);
    stop();
  endtask

  task automatic read_regs(input int n, output logic [7:0][7:0] q,
    output int acks);
    logic a;
    acks = 0;
    q = '1;
    start();
    put(8'hD3, acks);
    for (int i = 0; i < n; i++)
      xbyte(8'hFF, 1'(i == n - 1), q[i], a);
    stop();
  endtask
endmodule

/* tb/tb_clock_output_control_regs.sv */
`timescale 1ns/1ns
module tb_clock_output_control_regs
  import ckr_pkg::*;
;
  // Identifier byte; the value is arbitrary.
  localparam logic [7:0] ID = 8'h3C;
  // Writable bits of bytes seven down to zero.
  localparam logic [7:0][7:0] WM =
    {8'h00, 8'h00, 8'hFF, 8'hF5, 8'hB3, 8'h7F, 8'h2E, 8'hFF};
  // Write patterns; each pass writes two bytes fewer.
  localparam logic [3:0][7:0] PAT = {8'hFF, 8'hAA, 8'h55, 8'h00};
  logic clock;
  logic rst;
  logic [3:0] freq_strap;
  logic scl;
  logic host_pull;
  logic dev_out;
  logic dev_oe;
  ckr_run_s clock_run;
  logic [7:0] freq_ctrl_byte;
  logic [7:0][7:0] want;
  logic [7:0][7:0] got;
  logic [7:0][7:0] wdat;
  int acks;
  int failures;
  int tests_run;
  // The data line has a pull-up, so it is high unless someone pulls.
  wire sda = !host_pull && !(dev_oe && !dev_out);

  ckr_regs #(.CHIP_ID(ID)) uut (.clock(clock), .rst(rst),
    .serial_clock_in(scl), .serial_data_in(sda),
    .serial_data_out(dev_out), .serial_data_oe(dev_oe),
    .freq_strap(freq_strap), .clock_run(clock_run),
    .freq_ctrl_byte(freq_ctrl_byte));

  ckr_host_model host (.clock(clock), .sda(sda), .scl(scl),
    .sda_pull(host_pull));

  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Power-up reset; straps stay put from release onward.
  task automatic do_reset(input logic [3:0] s);
    rst <= 1'b1;
    freq_strap <= s;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    want = {8'hFF, ID, 8'hFF, {4'hF, ~s[1], 1'b1, ~s[3], 1'b1},
      {1'b1, ~s[0], 6'h3F}, 8'hFF, {~s[2], 7'h7F}, 8'h00};
  endtask

  // Every output field against the expected register image.
  task automatic check_outputs();
    ckr_run_s r;
    logic [7:0][7:0] x;
    logic [13:0] m;
    r = clock_run;
    x = want;
    m = {x[4][7:4], x[4][2], x[4][0], x[5]};
    chk("proc", 32'(x[1][3:1]), 32'(r.processor_clock_out));
    chk("spread", 32'(!x[1][5]), 32'(r.down_spread));
    chk("peri", 32'(x[2][6:0]), 32'(r.peripheral_bus_clock_out));
    chk("sel24", 32'(x[3][7]), 32'(r.selectable_is_24mhz));
    chk("f48", 32'(x[3][5]), 32'(r.fixed_48_out));
    chk("fsel", 32'(x[3][4]), 32'(r.selectable_fixed_out));
    chk("ref2", 32'(x[3][1]), 32'(r.second_reference_out));
    chk("rx2", 32'(x[3][0]), 32'(r.double_strength_reference_out));
    chk("memh", 32'(m[13:8]), 32'(r.memory_clock_out[13:8]));
    chk("meml", 32'(m[7:0]), 32'(r.memory_clock_out[7:0]));
    chk("reg0", 32'(x[0]), 32'(freq_ctrl_byte));
  endtask

  // Reads n bytes from index zero and compares each.
  task automatic check_read(input int n);
    host.read_regs(n, got, acks);
    chk("rdack", 32'd1, 32'(acks));
    for (int i = 0; i < n; i++)
      chk($sformatf("byte%0d", i), 32'(want[i]), 32'(got[i]));
  endtask

  // Writes n bytes and folds the writable bits into the image.
  task automatic write_n(input int n);
    host.write_regs(8'hD2, wdat, n, acks);
    chk("wrack", 32'(n + 3), 32'(acks));
    for (int i = 0; i < n; i++)
      want[i] = (want[i] & ~WM[i]) | (wdat[i] & WM[i]);
  endtask

  // A hang counts as a mismatch and ends the run the usual way.
  initial
  begin
    repeat (60000) @(posedge clock);
    failures++;
    finish_test();
  end

  initial
  begin
    rst = 1'b1;
    freq_strap = 4'h6;
    failures = 0;
    tests_run = 0;
    wdat = '0;
    do_reset(4'h6);
    check_outputs();
    check_read(8);
    // Varying length shows that bytes past the stop stay unchanged.
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 8; i++)
        wdat[i] = PAT[k] ^ 8'(i * 17);
      write_n(8 - 2 * k);
      check_outputs();
      check_read(8 - k);
    end
    // A foreign address must get no acknowledge and change nothing.
    wdat = '0;
    host.write_regs(8'hA2, wdat, 8, acks);
    chk("badaddr", 32'd0, 32'(acks));
    check_outputs();
    check_read(2);
    do_reset(4'h9);
    check_outputs();
    check_read(8);
    finish_test();
  end
endmodule
